// ==== swd_pkg.sv ====
// Package: constants and types for the supervisor watchdog timer
package swd_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned SWD_CLK_HZ = 50_000_000;
  // Timeout period in milliseconds
  localparam int unsigned SWD_TIMEOUT_MS = 1600;
  // Longest time rounds down to whole cycles
  localparam longint unsigned SWD_TIMEOUT_CYC_L =
    (64'(SWD_TIMEOUT_MS) * 64'(SWD_CLK_HZ)) / 64'd1000;
  localparam int unsigned SWD_TIMEOUT_CYC = 32'(SWD_TIMEOUT_CYC_L);
  localparam int SWD_CNT_W = 27;
  localparam logic [SWD_CNT_W-1:0] SWD_CNT_RST = 27'h000_0000;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Gray coded: idle -> armed -> tripped
  typedef enum logic [1:0] {
    SWD_IDLE = 2'b00,
    SWD_ARMED = 2'b01,
    SWD_TRIPPED = 2'b11
  } swd_state_t;

  // Kick synchroniser stages
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } swd_kick_sync_t;

  localparam swd_kick_sync_t SWD_SYNC_RST = 3'h0;

endpackage : swd_pkg

// ==== swd_watchdog.sv ====
// Module: supervisor watchdog timer core
`timescale 1ns/1ps

module swd_watchdog
  import swd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = swd_pkg::SWD_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable_jumper,
  input wire logic watchdog_kick_input,
  output logic watchdog_timeout_output_n,
  output logic timeout_active
);

  // ----------------------------------------
  // Kick synchroniser and edge detect
  // ----------------------------------------
  swd_kick_sync_t sync_reg;
  swd_kick_sync_t sync_next;
  logic kick_edge;

  always_comb begin
    sync_next.meta = watchdog_kick_input;
    sync_next.sync = sync_reg.meta;
    sync_next.last = sync_reg.sync;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_reg <= SWD_SYNC_RST;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Either edge counts as a kick; a held level never does
  assign kick_edge = sync_reg.sync ^ sync_reg.last;

  // ----------------------------------------
  // Timeout counter and state
  // ----------------------------------------
  localparam logic [SWD_CNT_W-1:0] TERM = SWD_CNT_W'(TIMEOUT_CYC - 1);

  swd_state_t state_reg;
  swd_state_t state_next;
  logic [SWD_CNT_W-1:0] cnt_reg;
  logic [SWD_CNT_W-1:0] cnt_next;
  logic out_n_reg;
  logic out_n_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    out_n_next = 1'b1;
    case (state_reg)
      SWD_IDLE: begin
        cnt_next = SWD_CNT_RST;
        if (enable_jumper) begin
          state_next = SWD_ARMED;
        end
      end
      SWD_ARMED: begin
        if (!enable_jumper) begin
          state_next = SWD_IDLE;
          cnt_next = SWD_CNT_RST;
        end else if (kick_edge) begin
          cnt_next = SWD_CNT_RST;
        end else if (cnt_reg == TERM) begin
          state_next = SWD_TRIPPED;
          cnt_next = SWD_CNT_RST;
          out_n_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + SWD_CNT_W'(1);
        end
      end
      SWD_TRIPPED: begin
        out_n_next = 1'b0;
        if (!enable_jumper) begin
          state_next = SWD_IDLE;
          out_n_next = 1'b1;
        end else if (kick_edge) begin
          state_next = SWD_ARMED;
          cnt_next = SWD_CNT_RST;
          out_n_next = 1'b1;
        end
      end
      default: begin
        state_next = SWD_IDLE;
        cnt_next = SWD_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= SWD_IDLE;
      cnt_reg <= SWD_CNT_RST;
      out_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      out_n_reg <= out_n_next;
    end
  end

  assign watchdog_timeout_output_n = out_n_reg;
  assign timeout_active = ~out_n_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_disabled_quiet;
    @(posedge clk) disable iff (!rstn)
      !enable_jumper |=> watchdog_timeout_output_n;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("timeout output low while jumper removed");

  property p_disabled_no_kick_effect;
    @(posedge clk) disable iff (!rstn)
      !enable_jumper [*2] |-> watchdog_timeout_output_n && state_reg != SWD_TRIPPED;
  endproperty
  a_disabled_no_kick_effect: assert property (p_disabled_no_kick_effect)
    else $error("watchdog active while disabled");

  property p_trip_at_term;
    @(posedge clk) disable iff (!rstn)
      state_reg == SWD_ARMED && enable_jumper && !kick_edge && cnt_reg == TERM
      |=> !watchdog_timeout_output_n && state_reg == SWD_TRIPPED;
  endproperty
  a_trip_at_term: assert property (p_trip_at_term)
    else $error("timeout not raised at terminal count");

  property p_no_early_trip;
    @(posedge clk) disable iff (!rstn)
      $fell(watchdog_timeout_output_n) |-> $past(cnt_reg) == TERM;
  endproperty
  a_no_early_trip: assert property (p_no_early_trip)
    else $error("timeout raised before terminal count");

  sequence s_tripped_no_kick;
    !watchdog_timeout_output_n && enable_jumper && !kick_edge;
  endsequence

  property p_hold_low;
    @(posedge clk) disable iff (!rstn)
      s_tripped_no_kick |=> !watchdog_timeout_output_n;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("timeout output released without kick");

  property p_release_on_kick;
    @(posedge clk) disable iff (!rstn)
      !watchdog_timeout_output_n && enable_jumper && kick_edge
      |=> watchdog_timeout_output_n && cnt_reg == SWD_CNT_RST;
  endproperty
  a_release_on_kick: assert property (p_release_on_kick)
    else $error("timeout output not released on kick");

  property p_edge_detect;
    @(posedge clk) disable iff (!rstn)
      $changed(sync_reg.sync) |-> kick_edge;
  endproperty
  a_edge_detect: assert property (p_edge_detect)
    else $error("kick edge missed");

  property p_kick_restarts;
    @(posedge clk) disable iff (!rstn)
      state_reg == SWD_ARMED && enable_jumper && kick_edge |=> cnt_reg == SWD_CNT_RST;
  endproperty
  a_kick_restarts: assert property (p_kick_restarts)
    else $error("kick did not restart counter");

  // ----------------------------------------
  // Consistency and release timing
  // ----------------------------------------
  property p_active_inverse;
    @(posedge clk) disable iff (!rstn)
      timeout_active == !watchdog_timeout_output_n;
  endproperty
  a_active_inverse: assert property (p_active_inverse)
    else $error("timeout flag and output disagree");

  property p_low_only_tripped;
    @(posedge clk) disable iff (!rstn)
      !watchdog_timeout_output_n |-> state_reg == SWD_TRIPPED;
  endproperty
  a_low_only_tripped: assert property (p_low_only_tripped)
    else $error("timeout output low outside tripped state");

  property p_idle_count_zero;
    @(posedge clk) disable iff (!rstn)
      state_reg == SWD_IDLE |-> cnt_reg == SWD_CNT_RST;
  endproperty
  a_idle_count_zero: assert property (p_idle_count_zero)
    else $error("counter runs while disabled");

  property p_count_bounded;
    @(posedge clk) disable iff (!rstn)
      cnt_reg <= TERM;
  endproperty
  a_count_bounded: assert property (p_count_bounded)
    else $error("counter passed terminal count");

  // Kick pin change while tripped, then two cycles of synchroniser latency
  sequence s_trip_kick;
    state_reg == SWD_TRIPPED && enable_jumper && $changed(watchdog_kick_input);
  endsequence

  sequence s_kick_settle;
    s_trip_kick ##1 enable_jumper ##1 enable_jumper;
  endsequence

  property p_kick_releases;
    @(posedge clk) disable iff (!rstn)
      s_kick_settle |=> watchdog_timeout_output_n;
  endproperty
  a_kick_releases: assert property (p_kick_releases)
    else $error("kick pin change did not release timeout output");

endmodule : swd_watchdog

// ==== swd_host.sv ====
// Host model that services the watchdog kick line
`timescale 1ns/1ps

module swd_host (
  input wire logic clk,
  input wire logic kick_req,
  output logic kick
);
  initial kick = 1'b0;
  // Service by changing the level, never by holding it
  always @(posedge clk) begin
    if (kick_req) kick <= ~kick;
  end
endmodule : swd_host

// ==== swd_watchdog_tb.sv ====
// Self-checking bench for the supervisor watchdog timer
`timescale 1ns/1ps
`define CHK(a, e) chk(a, e)

module swd_watchdog_tb;
  import swd_pkg::*;
  localparam int T = 16;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic jmp = 1'b0;
  logic kreq = 1'b0;
  logic kick;
  logic wdo_n;
  logic act;
  int fails = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  swd_host host (.clk(clk), .kick_req(kreq), .kick(kick));
  swd_watchdog #(.TIMEOUT_CYC(T)) dut (.clk(clk), .rstn(rstn), .enable_jumper(jmp),
    .watchdog_kick_input(kick), .watchdog_timeout_output_n(wdo_n), .timeout_active(act));

  task automatic chk(input logic a, input logic e);
    cmp_count++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, a, e);
    end
  endtask : chk

  task automatic test_done;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Run n cycles, kicking every k cycles (0 = never), output steady at e
  task automatic run(input int n, input int k, input logic e);
    for (int i = 1; i <= n; i++) begin
      @(negedge clk);
      `CHK(wdo_n, e);
      `CHK(act, ~e);
      kreq = (k != 0) && (i % k == 0);
    end
  endtask : run

  // Wait a bounded time for the output to reach e
  task automatic wait_out(input logic e);
    int n = 0;
    while (wdo_n !== e && n < 8) begin
      @(negedge clk);
      n++;
    end
    `CHK(wdo_n, e);
    `CHK(act, ~e);
  endtask : wait_out

  task automatic kick_once;
    kreq = 1'b1;
    @(negedge clk);
    kreq = 1'b0;
  endtask : kick_once

  task automatic sc_disabled;
    run(3 * T, 3, 1'b1);
    run(3 * T, 0, 1'b1);
  endtask : sc_disabled

  task automatic sc_serviced;
    jmp = 1'b1;
    run(4 * T, T / 2, 1'b1);
  endtask : sc_serviced

  task automatic sc_trip;
    run(T - 4, 0, 1'b1);
    wait_out(1'b0);
    run(3 * T, 0, 1'b0);
    kick_once();
    wait_out(1'b1);
    run(T - 4, 0, 1'b1);
    wait_out(1'b0);
    kick_once();
    wait_out(1'b1);
  endtask : sc_trip

  task automatic sc_unjumper;
    run(T - 4, 0, 1'b1);
    wait_out(1'b0);
    jmp = 1'b0;
    run(2 * T, 0, 1'b1);
  endtask : sc_unjumper

  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    sc_disabled();
    sc_serviced();
    sc_trip();
    sc_unjumper();
    test_done();
  end

  initial begin
    #50us;
    fails++;
    test_done();
  end
endmodule : swd_watchdog_tb
